// *** dv/pgef_host_model.sv ***
// host-side model of the register port: byte-wide writes and reads
`timescale 1ns/1ps
module pgef_host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // idle port at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one strobe cycle per write; idle lines show inverted values
  // callers clear flags by writing one after servicing, reserved bits zero except the 8'hff write to 8'h16
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  // read strobe for one edge, data taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the power-good and event flag block
`timescale 1ns/1ps
module testbench;
  logic       mclk, arst_n, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] rail_valid, enreq, reg_enable;
  logic       twarn, tsd, ovp, extclk, meas, lpend, spend, sdone;
  logic       g1req, g2req, gout1, gout2, pok, otp, sirst;
  int         error_cnt, checks_done;
  logic [7:0] addrs [7] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h30};

  pgef_top i_pgef_top (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rail_valid(rail_valid),
    .thermal_warning_live(twarn), .thermal_shutdown_live(tsd), .overvoltage_live(ovp),
    .ext_clock_present(extclk), .current_measure_ready(meas), .linear_reg_event_pending(lpend),
    .step_down_event_pending(spend), .startup_done(sdone), .reg_enable_request(enreq),
    .general_output_one_req(g1req), .general_output_two_req(g2req), .reg_enable(reg_enable),
    .general_output_one(gout1), .general_output_two(gout2), .power_ok_output(pok),
    .otp_reload(otp), .serial_if_reset(sirst));

  pgef_host_model i_pgef_host_model (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // compare, report and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_pgef_host_model.wr(a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_pgef_host_model.rd(a, d);
    chk(d, exp, $sformatf("read of %h", a));
  endtask

  // leaves room for the two-flop sync plus output register
  task automatic settle;
    repeat (5) @(posedge mclk);
    #1;
  endtask

  task automatic po(input logic e);
    settle();
    chk({7'h00, pok}, {7'h00, e}, "power ok level");
  endtask

  task automatic outs(input logic [7:0] e);
    chk({2'b00, reg_enable, gout1, gout2}, e, "enables and outputs");
  endtask

  task automatic te(input string n);
    $display("test %s finished", n);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    #100000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end

  // main sequence
  initial begin
    {arst_n, rail_valid, enreq, twarn, tsd, ovp, extclk} = '0;
    {meas, lpend, spend, sdone, g1req, g2req} = '0;
    error_cnt   = 0;
    checks_done = 0;
    repeat (4) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    foreach (addrs[i]) rc(addrs[i], 8'h00);
    w(8'h16, 8'hff);
    rc(8'h16, 8'h07);
    w(8'h16, 8'h00);
    te("reset values");
    // gated versus continuous mode on a disabled regulator
    {rail_valid, enreq, g1req, g2req} = 10'h3ff;
    settle();
    w(8'h15, 8'h0f);
    po(1'b1);
    enreq = 4'he;
    po(1'b0);
    w(8'h16, 8'h01);
    po(1'b1);
    rc(8'h17, 8'h01);
    w(8'h17, 8'h01);
    rc(8'h17, 8'h00);
    rc(8'h19, 8'h80);
    w(8'h19, 8'h00);
    rc(8'h19, 8'h80);
    w(8'h19, 8'h80);
    rc(8'h19, 8'h00);
    enreq = 4'hf;
    te("mode");
    // fault latch of an invalid rail and latch as output source
    rail_valid = 4'hb;
    po(1'b0);
    rc(8'h17, 8'h04);
    w(8'h17, 8'h04);
    rc(8'h17, 8'h04);
    w(8'h15, 8'h0b);
    po(1'b1);
    w(8'h15, 8'h0f);
    rail_valid = 4'hf;
    w(8'h16, 8'h03);
    po(1'b0);
    w(8'h16, 8'h01);
    po(1'b1);
    w(8'h16, 8'h03);
    w(8'h17, 8'h04);
    po(1'b1);
    rc(8'h17, 8'h00);
    w(8'h16, 8'h01);
    w(8'h19, 8'hff);
    w(8'h15, 8'h8f);
    po(1'b0);
    w(8'h15, 8'h0f);
    po(1'b1);
    te("fault latch");
    // thermal warning gate
    w(8'h16, 8'h05);
    twarn = 1'b1;
    po(1'b0);
    rc(8'h19, 8'h84);
    w(8'h16, 8'h01);
    po(1'b1);
    twarn = 1'b0;
    settle();
    w(8'h19, 8'h84);
    rc(8'h19, 8'h00);
    te("warning gate");
    // trips: shutdown latched, overvoltage live
    tsd = 1'b1;
    settle();
    outs(8'h00);
    rc(8'h19, 8'h08);
    w(8'h19, 8'h08);
    rc(8'h19, 8'h08);
    tsd = 1'b0;
    settle();
    outs(8'h00);
    w(8'h19, 8'h08);
    settle();
    outs(8'h3f);
    ovp = 1'b1;
    settle();
    outs(8'h00);
    rc(8'h19, 8'h02);
    ovp = 1'b0;
    settle();
    w(8'h19, 8'h02);
    outs(8'h3f);
    te("trips");
    // clock, measurement and summary flags
    extclk = 1'b1;
    settle();
    rc(8'h19, 8'h10);
    w(8'h19, 8'h10);
    extclk = 1'b0;
    settle();
    rc(8'h19, 8'h10);
    w(8'h19, 8'h10);
    meas = 1'b1;
    settle();
    rc(8'h19, 8'h01);
    w(8'h19, 8'h01);
    rc(8'h19, 8'h00);
    {meas, lpend, spend} = 3'b011;
    settle();
    w(8'h19, 8'h60);
    rc(8'h19, 8'h60);
    {lpend, spend} = 2'b00;
    settle();
    rc(8'h19, 8'h00);
    te("events");
    // software reset and startup flag
    w(8'h18, 8'h01);
    chk({6'h00, otp, sirst}, 8'h03, "reset pulses");
    rc(8'h18, 8'h00);
    rc(8'h15, 8'h00);
    rc(8'h16, 8'h00);
    sdone = 1'b1;
    @(posedge mclk);
    #1;
    sdone = 1'b0;
    rc(8'h1a, 8'h01);
    w(8'h1a, 8'h01);
    rc(8'h1a, 8'h00);
    te("software reset");
    test_done();
  end
endmodule

// *** src/pgef_params.svh ***
// offsets, field positions and reset values of the power-good and event flag block
`ifndef PGEF_PARAMS_SVH
`define PGEF_PARAMS_SVH

// register offsets on the serial register port
`define PGEF_OFS_PG_CTRL1   8'h15
`define PGEF_OFS_PG_CTRL2   8'h16
`define PGEF_OFS_RAIL_FLT   8'h17
`define PGEF_OFS_SOFT_RESET 8'h18
`define PGEF_OFS_TOP_EVENT  8'h19
`define PGEF_OFS_TOP_EVENT2 8'h1a

// power_good_control_one fields
`define PGEF_CTRL1_POL      7
`define PGEF_CTRL1_OD       6

// power_good_control_two fields
`define PGEF_CTRL2_TWARN    2
`define PGEF_CTRL2_FLTSRC   1
`define PGEF_CTRL2_MODE     0
`define PGEF_CTRL2_MASK     8'h07

// fault latch width, software reset bit
`define PGEF_FAULT_MASK     8'h0f
`define PGEF_SWRST_BIT      0

// top event flag positions
`define PGEF_EV_PGFALL      7
`define PGEF_EV_LDO         6
`define PGEF_EV_BUCK        5
`define PGEF_EV_EXTCLK      4
`define PGEF_EV_TSD         3
`define PGEF_EV_TWARN       2
`define PGEF_EV_OVP         1
`define PGEF_EV_MEAS        0
`define PGEF_EV_W1C_MASK    8'h9f

// reset values
`define PGEF_RST_CTRL1      8'h00
`define PGEF_RST_CTRL2      8'h00
`define PGEF_RST_FLAGS      8'h00

`endif

// *** src/pgef_pkg.sv ***
// types shared by the power-good and event flag block
package pgef_pkg;
  typedef logic [7:0] pgef_byte_t;
  typedef logic [3:0] pgef_rail_t;
  typedef enum logic {PGEF_SRC_LIVE, PGEF_SRC_LATCH} pgef_src_t;
endpackage

// *** src/pgef_sync.sv ***
// two-flop synchroniser for asynchronous status levels
`timescale 1ns/1ps
module pgef_sync #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// *** src/pgef_top.sv ***
// power-good qualification, rail fault latch, software reset and top event flags
//
// What this block does
// RQ1 - thermal-warning gate bit forces power-ok inactive while warning is live
// RQ2 - source select: live rail status, or inactive when any fault latch bit set
// RQ3 - control bit 0 selects gated mode (0) or continuous mode (1)
// RQ4 - fault latch bit sets for a monitored rail that went invalid; resets zero
// RQ5 - fault latch bit clears on write one only while its rail is valid
// RQ6 - software reset restores defaults, reloads OTP, resets serial interface
// RQ7 - software reset bit clears itself and reads back zero
// RQ8 - power-ok fall event latches on active to inactive change only
// RQ9 - linear regulator summary flag is read-only, mirrors pending event register
// RQ10 - step-down summary flag is read-only, mirrors pending event register
// RQ11 - external clock event latches when clock appears or disappears
// RQ12 - thermal shutdown latches flag, disables regulators, drives outputs low
// RQ13 - regulators refused while latched thermal shutdown flag stays set
// RQ14 - thermal warning latches flag; live state kept separately
// RQ15 - overvoltage latches flag, disables regulators, drives outputs low
// RQ16 - measurement done flag latches when new current result is ready
// RQ17 - writable event flags reset to zero and clear on write one
// RQ18 - polarity bit: 0 output high when valid, 1 output low when valid
// RQ19 - each rail has a monitor enable; only enabled rails are considered
// RQ20 - reset event flag sets when startup completes after undervoltage or soft reset
// RQ21 - writing zero leaves flags alone; an event beats a same-cycle clear
// RQ22 - reserved bits read zero and writes to them do nothing, except power_good_control_one bits 5:4, which store and read back
`timescale 1ns/1ps
`include "pgef_params.svh"
module pgef_top
  import pgef_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [3:0] rail_valid,
  input  wire logic       thermal_warning_live,
  input  wire logic       thermal_shutdown_live,
  input  wire logic       overvoltage_live,
  input  wire logic       ext_clock_present,
  input  wire logic       current_measure_ready,
  input  wire logic       linear_reg_event_pending,
  input  wire logic       step_down_event_pending,
  input  wire logic       startup_done,
  input  wire logic [3:0] reg_enable_request,
  input  wire logic       general_output_one_req,
  input  wire logic       general_output_two_req,
  output logic [3:0]      reg_enable,
  output logic            general_output_one,
  output logic            general_output_two,
  output logic            power_ok_output,
  output logic            otp_reload,
  output logic            serial_if_reset
);

  //////////////////////////////////////////////////////////////////////////////
  // synchronised analog status levels

  logic [7:0] async_bus;
  logic [7:0] sync_bus;
  pgef_rail_t valid_s;
  logic       twarn_s;
  logic       tsd_s;
  logic       ovp_s;
  logic       extclk_s;

  assign async_bus = {thermal_warning_live, thermal_shutdown_live, overvoltage_live,
                      ext_clock_present, rail_valid};

  pgef_sync #(.W(8)) u_sync (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .async_in (async_bus),
    .sync_out (sync_bus)
  );

  assign valid_s  = sync_bus[3:0];
  assign extclk_s = sync_bus[4];
  assign ovp_s    = sync_bus[5];
  assign tsd_s    = sync_bus[6];
  assign twarn_s  = sync_bus[7];

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // write-one-to-clear with the event winning over the clear
  function automatic pgef_byte_t w1c(input pgef_byte_t cur, input pgef_byte_t set,
                                     input pgef_byte_t clr);
    w1c = set | (cur & ~clr);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // register state

  pgef_byte_t ctrl1_q, ctrl1_d;
  pgef_byte_t ctrl2_q, ctrl2_d;
  pgef_rail_t fault_q, fault_d;
  pgef_byte_t event_q, event_d;
  logic       rst_ev_q, rst_ev_d;
  logic       swrst_q, swrst_d;
  logic       ok_q, ok_d;
  logic       extclk_q, extclk_d;
  logic       meas_q, meas_d;
  pgef_byte_t rdata_d;
  logic [3:0] en_d;
  logic       gen1_d;
  logic       gen2_d;
  logic       pin_d;

  pgef_src_t  src;
  pgef_rail_t monitor;
  pgef_rail_t rail_ok;
  pgef_rail_t fault_set;
  pgef_rail_t fault_clr;
  logic       live_ok;
  logic       good;
  logic       trip;
  pgef_byte_t ev_set;
  pgef_byte_t ev_clr;

  // power-ok qualification
  always_comb begin
    src     = ctrl2_q[`PGEF_CTRL2_FLTSRC] ? PGEF_SRC_LATCH : PGEF_SRC_LIVE;
    monitor = ctrl1_q[3:0];                                       // RQ19
    // gated mode also needs the regulator switched on; continuous looks at the comparator only
    rail_ok = ctrl2_q[`PGEF_CTRL2_MODE] ? valid_s : (valid_s & reg_enable); // RQ3
    live_ok = &(~monitor | rail_ok);                              // RQ19
    fault_set = monitor & ~rail_ok;                               // RQ4
    if (src == PGEF_SRC_LATCH) begin
      good = ~|fault_q;                                           // RQ2
    end else begin
      good = live_ok;                                             // RQ2
    end
    if (ctrl2_q[`PGEF_CTRL2_TWARN] && twarn_s) begin
      good = 1'b0;                                                // RQ1
    end
  end

  // write decode for the clearable registers
  always_comb begin
    fault_clr = '0;
    ev_clr    = '0;
    if (reg_wr && hit(reg_addr, `PGEF_OFS_RAIL_FLT)) begin
      fault_clr = reg_wdata[3:0] & rail_ok;                       // RQ5
    end
    if (reg_wr && hit(reg_addr, `PGEF_OFS_TOP_EVENT)) begin
      ev_clr = reg_wdata & `PGEF_EV_W1C_MASK;                     // RQ17
    end
  end

  // event sources
  always_comb begin
    ev_set = '0;
    ev_set[`PGEF_EV_PGFALL] = ok_q & ~good;                       // RQ8
    ev_set[`PGEF_EV_EXTCLK] = extclk_q ^ extclk_s;                // RQ11
    ev_set[`PGEF_EV_TSD]    = tsd_s;                              // RQ12
    ev_set[`PGEF_EV_TWARN]  = twarn_s;                            // RQ14
    ev_set[`PGEF_EV_OVP]    = ovp_s;                              // RQ15
    ev_set[`PGEF_EV_MEAS]   = current_measure_ready & ~meas_q;    // RQ16
  end

  // next state of every state register
  always_comb begin
    ctrl1_d  = ctrl1_q;
    ctrl2_d  = ctrl2_q;
    swrst_d  = 1'b0;                                              // RQ7
    fault_d  = (fault_set | (fault_q & ~fault_clr));              // RQ21
    event_d  = w1c(event_q, ev_set, ev_clr) & `PGEF_EV_W1C_MASK;  // RQ21
    rst_ev_d = rst_ev_q;
    ok_d     = good;
    extclk_d = extclk_s;
    meas_d   = current_measure_ready;
    if (reg_wr && hit(reg_addr, `PGEF_OFS_PG_CTRL1)) begin
      ctrl1_d = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `PGEF_OFS_PG_CTRL2)) begin
      ctrl2_d = reg_wdata & `PGEF_CTRL2_MASK;                     // RQ22
    end
    if (reg_wr && hit(reg_addr, `PGEF_OFS_SOFT_RESET)) begin
      swrst_d = reg_wdata[`PGEF_SWRST_BIT];
    end
    if (reg_wr && hit(reg_addr, `PGEF_OFS_TOP_EVENT2) && reg_wdata[0]) begin
      rst_ev_d = 1'b0;
    end
    if (swrst_q) begin
      // one-cycle pulse returns the control, fault latch, event flag and reset flag registers to their defaults
      ctrl1_d  = `PGEF_RST_CTRL1;                                 // RQ6
      ctrl2_d  = `PGEF_RST_CTRL2;
      fault_d  = '0;
      event_d  = `PGEF_RST_FLAGS;
      rst_ev_d = 1'b0;
      swrst_d  = 1'b0;
    end
    // a startup completion in the reset cycle still sets the flag
    if (startup_done) begin
      rst_ev_d = 1'b1;                                            // RQ20
    end
  end

  // readback and outputs
  always_comb begin
    trip   = event_q[`PGEF_EV_TSD] | ovp_s;
    en_d   = trip ? 4'h0 : reg_enable_request;                    // RQ13
    gen1_d = general_output_one_req & ~trip;                      // RQ12
    gen2_d = general_output_two_req & ~trip;                      // RQ15
    pin_d  = good ^ ctrl1_q[`PGEF_CTRL1_POL];                     // RQ18
    rdata_d = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        `PGEF_OFS_PG_CTRL1:   rdata_d = ctrl1_q;
        `PGEF_OFS_PG_CTRL2:   rdata_d = ctrl2_q;
        `PGEF_OFS_RAIL_FLT:   rdata_d = {4'h0, fault_q};          // RQ22
        `PGEF_OFS_SOFT_RESET: rdata_d = 8'h00;                    // RQ7
        `PGEF_OFS_TOP_EVENT: begin
          rdata_d = event_q;
          rdata_d[`PGEF_EV_LDO]  = linear_reg_event_pending;      // RQ9
          rdata_d[`PGEF_EV_BUCK] = step_down_event_pending;       // RQ10
        end
        `PGEF_OFS_TOP_EVENT2: rdata_d = {7'h00, rst_ev_q};
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  // state registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl1_q  <= `PGEF_RST_CTRL1;
      ctrl2_q  <= `PGEF_RST_CTRL2;
      fault_q  <= '0;
      event_q  <= `PGEF_RST_FLAGS;
      rst_ev_q <= 1'b0;
      swrst_q  <= 1'b0;
      ok_q     <= 1'b0;
      extclk_q <= 1'b0;
      meas_q   <= 1'b0;
    end else begin
      ctrl1_q  <= ctrl1_d;
      ctrl2_q  <= ctrl2_d;
      fault_q  <= fault_d;
      event_q  <= event_d;
      rst_ev_q <= rst_ev_d;
      swrst_q  <= swrst_d;
      ok_q     <= ok_d;
      extclk_q <= extclk_d;
      meas_q   <= meas_d;
    end
  end

  // output registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata          <= 8'h00;
      reg_enable         <= 4'h0;
      general_output_one <= 1'b0;
      general_output_two <= 1'b0;
      power_ok_output    <= 1'b0;
      otp_reload         <= 1'b0;
      serial_if_reset    <= 1'b0;
    end else begin
      reg_rdata          <= rdata_d;
      reg_enable         <= en_d;
      general_output_one <= gen1_d;
      general_output_two <= gen2_d;
      power_ok_output    <= pin_d;
      otp_reload         <= swrst_d;                              // RQ6
      serial_if_reset    <= swrst_d;                              // RQ6
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_swrst_write;
    reg_wr && hit(reg_addr, `PGEF_OFS_SOFT_RESET) && reg_wdata[0] && !swrst_q;
  endsequence

  sequence s_defaults;
    ctrl1_q == 8'h00 && ctrl2_q == 8'h00 && fault_q == 4'h0 && event_q == 8'h00;
  endsequence

  property p_twarn_gate;
    ctrl2_q[`PGEF_CTRL2_TWARN] && twarn_s |=> power_ok_output == $past(ctrl1_q[`PGEF_CTRL1_POL]);
  endproperty
  a_twarn_gate: assert property (p_twarn_gate) else $error("power-ok not forced off"); // RQ1

  property p_latch_source;
    ctrl2_q[`PGEF_CTRL2_FLTSRC] && !ctrl2_q[`PGEF_CTRL2_TWARN] && fault_q != 4'h0
      |=> power_ok_output == $past(ctrl1_q[`PGEF_CTRL1_POL]);
  endproperty
  a_latch_source: assert property (p_latch_source) else $error("latched fault not shown"); // RQ2

  property p_fault_set;
    (monitor[0] && !rail_ok[0]) |=> fault_q[0] || $past(swrst_q);
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault latch missed"); // RQ4

  property p_fault_hold;
    fault_q[1] && !(reg_wr && hit(reg_addr, `PGEF_OFS_RAIL_FLT) && rail_ok[1]) && !swrst_q
      |=> fault_q[1];
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault latch lost"); // RQ5

  property p_swrst;
    s_swrst_write |=> swrst_q && otp_reload && serial_if_reset ##1 s_defaults;
  endproperty
  a_swrst: assert property (p_swrst) else $error("soft reset incomplete"); // RQ6

  property p_swrst_selfclear;
    swrst_q |=> !swrst_q;
  endproperty
  a_swrst_selfclear: assert property (p_swrst_selfclear) else $error("reset bit stuck"); // RQ7

  property p_fall_event;
    ok_q && !good && !swrst_q |=> event_q[`PGEF_EV_PGFALL];
  endproperty
  a_fall_event: assert property (p_fall_event) else $error("fall event missed"); // RQ8

  property p_tsd_refuse;
    event_q[`PGEF_EV_TSD] |=> reg_enable == 4'h0 && !general_output_one && !general_output_two;
  endproperty
  a_tsd_refuse: assert property (p_tsd_refuse) else $error("regulator enabled in shutdown"); // RQ13

  property p_ovp_off;
    ovp_s |=> reg_enable == 4'h0 && !general_output_one && !general_output_two;
  endproperty
  a_ovp_off: assert property (p_ovp_off) else $error("regulator on in overvoltage"); // RQ15

  property p_set_wins;
    tsd_s && !swrst_q |=> event_q[`PGEF_EV_TSD];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear"); // RQ21

  property p_reserved;
    reg_rd && hit(reg_addr, `PGEF_OFS_RAIL_FLT) |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero"); // RQ22

endmodule
